/* File: hw/pvc_cnt.sv */
`timescale 1ns/1ps
`default_nettype none
module pvc_cnt #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // pulses in, ratio, pulse out
    input wire logic tick_in,
    input wire logic [W-1:0] ratio,
    output logic pulse_out
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic pulse;
    } pvc_cnt_s;

    pvc_cnt_s s_q;
    pvc_cnt_s s_d;

    initial begin
        if (W < 1) begin
            $error("pvc_cnt width must be at least one");
        end
    end

    // one output pulse per ratio input pulses, ratio zero acts as one
    always_comb begin
        s_d = s_q;
        s_d.pulse = 1'b0;
        if (tick_in) begin
            if (s_q.cnt + 1'b1 >= ratio || ratio <= {{(W-1){1'b0}}, 1'b1}) begin
                s_d.cnt = '0;
                s_d.pulse = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pulse_out = s_q.pulse;
endmodule
`default_nettype wire

/* File: hw/pvc_pkg.sv */
package pvc_pkg;
    // fractional resolution and field widths
    localparam int FRAC_W = 25;
    localparam int INTEGER_DIVIDE_VALUE_W = 16;
    localparam int REFERENCE_DIVIDER_W = 13;
    localparam int TSCL_W = 8;
    localparam int OSC_W = 2;
    localparam int CAP_W = 8;
    localparam int NUM_OSC = 4;
    localparam int RB_W = 32;
    localparam int OVF_W = 10;
    // read-back field positions
    localparam int RB_OSC_LSB = 22;
    localparam int RB_CAP_LSB = 13;
    // prescaler moduli as shifts and masks
    localparam int PRE_SHIFT_SMALL = 2;
    localparam int PRE_SHIFT_LARGE = 3;
    localparam logic [INTEGER_DIVIDE_VALUE_W-1:0] PRE_MASK_SMALL = 16'h0003;
    localparam logic [INTEGER_DIVIDE_VALUE_W-1:0] PRE_MASK_LARGE = 16'h0007;
    // calibration start points and worst case tick budgets
    localparam logic [OSC_W-1:0] OSC_MID = 2'h2;
    localparam logic [CAP_W-1:0] CAP_MID = 8'h80;
    localparam logic [3:0] OSC_TOP_BIT = 4'h1;
    localparam logic [3:0] CAP_TOP_BIT = 4'h7;
    localparam int AUTO_TICKS_MAX = 23;
    localparam int FIXED_TICKS_MAX = 17;
    // calibration sequencer
    typedef enum logic [1:0] {
        PVC_IDLE = 2'b00,
        PVC_SETTLE = 2'b01,
        PVC_APPLY = 2'b10,
        PVC_JUDGE = 2'b11
    } pvc_cal_e;
endpackage

/* File: hw/pvc_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - integer mode divides by the integer value exactly, fraction bits ignored
// - fractional mode divides by integer plus fraction over two to the 25
// - phase comparison runs at reference pulses divided by reference divider
// - feedback is predivider, 4/5 or 8/9 prescaler, then A and M counters
// - divider derives A and M itself for either prescaler setting
// - four oscillators with own capacitor banks, exactly one active
// - trigger starts calibration at once; settings must already be valid
// - calibration searches oscillator and capacitor to meet tuning target
// - calibration tick is comparison rate scaled; software keeps it 0.1 to 1 MHz
// - counter overflow during calibration sets a flag; result then invalid
// - automatic oscillator choice finishes within 23 calibration ticks
// - fixed oscillator choice searches capacitors only, within 17 ticks
// - results never overwrite programmed choice; they drive oscillator, capacitor and read-back
// - manual tuning bypasses calibration and drives programmed choice directly
// - loop leaves calibration mode when calibration ends
// - outputs disabled from power-up until a calibration completes without overflow or manual tuning is selected
// - read-back shows chosen oscillator in 23:22 and capacitor in 20:13
module pvc_top
    import pvc_pkg::*;
#(
    parameter int INTEGER_DIVIDE_VALUE_WIDTH = pvc_pkg::INTEGER_DIVIDE_VALUE_W,
    parameter int OVF_WIDTH = pvc_pkg::OVF_W
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // analog side events
    input wire logic ref_pulse,
    input wire logic presc_pulse,
    input wire logic tune_above_target,
    // divider settings
    input wire logic fractional_mode,
    input wire logic [pvc_pkg::INTEGER_DIVIDE_VALUE_W-1:0] integer_divide_value,
    input wire logic [pvc_pkg::FRAC_W-1:0] fraction_divide_value,
    input wire logic [pvc_pkg::REFERENCE_DIVIDER_W-1:0] reference_divider,
    input wire logic [2:0] feedback_predivide_select,
    input wire logic prescaler_select,
    input wire logic [1:0] output_divide_select,
    // calibration settings
    input wire logic [pvc_pkg::TSCL_W-1:0] calibration_tick_scale,
    input wire logic calibration_trigger,
    input wire logic [1:0] calibration_accuracy,
    input wire logic [1:0] tune_voltage_target,
    input wire logic oscillator_choice_mode,
    input wire logic [pvc_pkg::OSC_W-1:0] oscillator_choice,
    input wire logic [pvc_pkg::CAP_W-1:0] capacitor_bank_code,
    input wire logic manual_tuning_select,
    input wire logic output_enable_request,
    // divider controls
    output logic pfd_tick,
    output logic fb_pulse,
    output logic modulus_ctrl,
    output logic [2:0] predivide_ctrl,
    output logic prescaler_ctrl,
    output logic [1:0] lo_divide_ctrl,
    // oscillator controls
    output logic [pvc_pkg::NUM_OSC-1:0] osc_enable,
    output logic [pvc_pkg::CAP_W-1:0] cap_code,
    output logic [1:0] cal_precision,
    output logic [1:0] tune_target_ctrl,
    // status
    output logic cal_active,
    output logic cal_done,
    output logic cal_counter_overflow_flag,
    output logic [pvc_pkg::RB_W-1:0] readback_word,
    output logic rf_lo_enable
);
    import pvc_pkg::*;

    typedef struct packed {
        logic [FRAC_W-1:0] acc;
        logic [INTEGER_DIVIDE_VALUE_W-1:0] fb_cnt;
        logic [INTEGER_DIVIDE_VALUE_W-1:0] m_val;
        logic [INTEGER_DIVIDE_VALUE_W-1:0] a_val;
        logic fb_pulse;
        logic modulus;
        pvc_cal_e st;
        logic osc_phase;
        logic [3:0] bit_idx;
        logic [OSC_W-1:0] trial_osc;
        logic [CAP_W-1:0] trial_cap;
        logic [OSC_W-1:0] res_osc;
        logic [CAP_W-1:0] res_cap;
        logic [OVF_W-1:0] ovf_cnt;
        logic active;
        logic done;
        logic ovf;
        logic [NUM_OSC-1:0] osc_en;
        logic [CAP_W-1:0] cap;
        logic [RB_W-1:0] rb;
        logic out_en;
        logic [2:0] predivide;
        logic prescaler;
        logic [1:0] lo_div;
        logic [1:0] precision;
        logic [1:0] target;
    } pvc_top_s;

    pvc_top_s s_q;
    pvc_top_s s_d;
    logic cal_tick;
    logic pfd_int;
    logic [FRAC_W:0] acc_sum;
    logic [INTEGER_DIVIDE_VALUE_W-1:0] n_next;
    logic [OSC_W-1:0] act_osc;

    initial begin
        if (INTEGER_DIVIDE_VALUE_WIDTH != INTEGER_DIVIDE_VALUE_W || OVF_WIDTH != OVF_W) begin
            $error("pvc_top widths must match the package");
        end
    end

    // comparison rate from the reference
    pvc_cnt #(.W(REFERENCE_DIVIDER_W)) u_ref_div (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick_in(ref_pulse),
        .ratio(reference_divider),
        .pulse_out(pfd_int)
    );

    // calibration tick from the comparison rate
    pvc_cnt #(.W(TSCL_W)) u_cal_div (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick_in(pfd_int),
        .ratio(calibration_tick_scale),
        .pulse_out(cal_tick)
    );

    // modulator sum and next division; integer mode adds no carry
    always_comb begin
        acc_sum = {1'b0, s_q.acc} + {1'b0, fraction_divide_value};
        if (fractional_mode) begin
            n_next = integer_divide_value + {{(INTEGER_DIVIDE_VALUE_W-1){1'b0}}, acc_sum[FRAC_W]};
        end else begin
            n_next = integer_divide_value;
        end
    end

    // next state
    always_comb begin
        s_d = s_q;
        s_d.fb_pulse = 1'b0;
        // dual modulus counting: prescaler pulses per cycle equal M
        if (presc_pulse) begin
            if (s_q.fb_cnt + 1'b1 >= s_q.m_val) begin
                s_d.fb_cnt = '0;
                s_d.fb_pulse = 1'b1;
                s_d.acc = fractional_mode ? acc_sum[FRAC_W-1:0] : '0;
                if (prescaler_select) begin
                    s_d.m_val = n_next >> PRE_SHIFT_LARGE;
                    s_d.a_val = n_next & PRE_MASK_LARGE;
                end else begin
                    s_d.m_val = n_next >> PRE_SHIFT_SMALL;
                    s_d.a_val = n_next & PRE_MASK_SMALL;
                end
            end else begin
                s_d.fb_cnt = s_q.fb_cnt + 1'b1;
            end
        end
        s_d.modulus = s_d.fb_cnt < s_d.a_val;
        s_d.predivide = feedback_predivide_select;
        s_d.prescaler = prescaler_select;
        s_d.lo_div = output_divide_select;
        s_d.precision = calibration_accuracy;
        s_d.target = tune_voltage_target;
        // overflow watch: feedback cycles per calibration tick
        if (cal_tick) begin
            s_d.ovf_cnt = '0;
        end else if (s_q.active && s_q.fb_pulse) begin
            if (&s_q.ovf_cnt) begin
                s_d.ovf = 1'b1;
            end else begin
                s_d.ovf_cnt = s_q.ovf_cnt + 1'b1;
            end
        end
        // calibration sequencer, one step per tick
        case (s_q.st)
            PVC_IDLE: begin
            end
            PVC_SETTLE, PVC_APPLY: begin
                if (cal_tick) begin
                    s_d.st = PVC_JUDGE;
                end
            end
            PVC_JUDGE: begin
                if (cal_tick) begin
                    if (s_q.osc_phase) begin
                        if (!tune_above_target) begin
                            s_d.trial_osc[s_q.bit_idx[0]] = 1'b0;
                        end
                        if (s_q.bit_idx == 4'h0) begin
                            s_d.osc_phase = 1'b0;
                            s_d.bit_idx = CAP_TOP_BIT;
                            s_d.trial_cap = CAP_MID;
                        end else begin
                            s_d.bit_idx = s_q.bit_idx - 1'b1;
                            s_d.trial_osc[0] = 1'b1;
                        end
                        s_d.st = PVC_APPLY;
                    end else begin
                        if (!tune_above_target) begin
                            s_d.trial_cap[s_q.bit_idx[2:0]] = 1'b0;
                        end
                        if (s_q.bit_idx == 4'h0) begin
                            s_d.st = PVC_IDLE;
                            s_d.active = 1'b0;
                            s_d.done = 1'b1;
                            s_d.res_osc = s_q.trial_osc;
                            s_d.res_cap = s_d.trial_cap;
                        end else begin
                            s_d.bit_idx = s_q.bit_idx - 1'b1;
                            s_d.trial_cap[s_q.bit_idx[2:0] - 3'h1] = 1'b1;
                            s_d.st = PVC_APPLY;
                        end
                    end
                end
            end
            default: begin
                s_d.st = PVC_IDLE;
            end
        endcase
        // trigger starts at once; manual tuning stops any search
        if (manual_tuning_select) begin
            s_d.st = PVC_IDLE;
            s_d.active = 1'b0;
        end else if (calibration_trigger) begin
            s_d.st = PVC_SETTLE;
            s_d.active = 1'b1;
            s_d.done = 1'b0;
            s_d.ovf = s_d.ovf & s_q.active & s_q.fb_pulse & (&s_q.ovf_cnt);
            s_d.ovf_cnt = '0;
            s_d.osc_phase = !oscillator_choice_mode;
            s_d.bit_idx = oscillator_choice_mode ? CAP_TOP_BIT : OSC_TOP_BIT;
            s_d.trial_osc = oscillator_choice_mode ? oscillator_choice : OSC_MID;
            s_d.trial_cap = CAP_MID;
        end
        // one oscillator and one capacitor code drive the analog side
        if (manual_tuning_select) begin
            act_osc = oscillator_choice;
            s_d.cap = capacitor_bank_code;
        end else if (s_d.active) begin
            act_osc = s_d.trial_osc;
            s_d.cap = s_d.trial_cap;
        end else begin
            act_osc = s_d.res_osc;
            s_d.cap = s_d.res_cap;
        end
        s_d.osc_en = '0;
        s_d.osc_en[act_osc] = 1'b1;
        // read-back carries only the search result
        s_d.rb = '0;
        s_d.rb[RB_OSC_LSB +: OSC_W] = s_d.res_osc;
        s_d.rb[RB_CAP_LSB +: CAP_W] = s_d.res_cap;
        // outputs held off until a clean calibration or manual tuning
        s_d.out_en = output_enable_request && !s_d.active &&
            (manual_tuning_select || (s_d.done && !s_d.ovf));
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.st <= PVC_IDLE;
            s_q.osc_en <= {{(NUM_OSC-1){1'b0}}, 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign pfd_tick = pfd_int;
    assign fb_pulse = s_q.fb_pulse;
    assign modulus_ctrl = s_q.modulus;
    assign predivide_ctrl = s_q.predivide;
    assign prescaler_ctrl = s_q.prescaler;
    assign lo_divide_ctrl = s_q.lo_div;
    assign osc_enable = s_q.osc_en;
    assign cap_code = s_q.cap;
    assign cal_precision = s_q.precision;
    assign tune_target_ctrl = s_q.target;
    assign cal_active = s_q.active;
    assign cal_done = s_q.done;
    assign cal_counter_overflow_flag = s_q.ovf;
    assign readback_word = s_q.rb;
    assign rf_lo_enable = s_q.out_en;

    // helper: ticks spent in the current calibration
    logic [5:0] tick_run_q;
    always_ff @(posedge sys_clk) begin
        if (rst || calibration_trigger) begin
            tick_run_q <= '0;
        end else if (s_q.active && cal_tick && tick_run_q != 6'h3F) begin
            tick_run_q <= tick_run_q + 6'h01;
        end
    end

    // helper: search kind latched when a calibration starts
    logic fixed_run_q;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fixed_run_q <= 1'b0;
        end else if (calibration_trigger && !manual_tuning_select) begin
            fixed_run_q <= oscillator_choice_mode;
        end
    end

    a_auto_tick_bound: assert property (@(posedge sys_clk) disable iff (rst)
        (s_q.active && !fixed_run_q) |-> tick_run_q < AUTO_TICKS_MAX)
        else $error("automatic calibration exceeds its tick budget");
    a_fixed_tick_bound: assert property (@(posedge sys_clk) disable iff (rst)
        (s_q.active && fixed_run_q) |-> tick_run_q < FIXED_TICKS_MAX)
        else $error("fixed oscillator calibration overruns");
    a_one_osc_on: assert property (@(posedge sys_clk) disable iff (rst)
        $onehot(osc_enable))
        else $error("oscillator enables not one-hot");
    a_manual_follow: assert property (@(posedge sys_clk) disable iff (rst)
        (manual_tuning_select && $past(manual_tuning_select)) |=>
        cap_code == $past(capacitor_bank_code) && !cal_active)
        else $error("manual tuning not followed");
    a_trigger_starts: assert property (@(posedge sys_clk) disable iff (rst)
        (calibration_trigger && !manual_tuning_select) |=> cal_active && !cal_done)
        else $error("trigger did not start calibration");
    a_outputs_gated: assert property (@(posedge sys_clk) disable iff (rst)
        cal_active |-> !rf_lo_enable)
        else $error("outputs enabled during calibration");
    a_readback_fields: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(cal_done) |=> readback_word[23:22] == $past(s_q.res_osc) &&
        readback_word[20:13] == $past(s_q.res_cap))
        else $error("read-back fields wrong");
    a_result_held: assert property (@(posedge sys_clk) disable iff (rst)
        (!cal_active && !manual_tuning_select && !calibration_trigger && !$past(cal_active)
        && !$past(manual_tuning_select)) |=> $stable(s_q.res_cap))
        else $error("held calibration result changed");
    a_integer_no_frac: assert property (@(posedge sys_clk) disable iff (rst)
        (!fractional_mode && presc_pulse && s_q.fb_cnt + 1'b1 >= s_q.m_val) |=> s_q.acc == '0)
        else $error("fraction used in integer mode");
    a_release_loop: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(cal_active) && !$past(manual_tuning_select) |-> cal_done)
        else $error("loop released without completion");
endmodule
`default_nettype wire

/* File: verif/pvc_analog_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pvc_analog_model
    import pvc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // test knobs
    input wire logic [7:0] ref_period,
    input wire logic [9:0] tune_point,
    // device controls
    input wire logic prescaler_ctrl,
    input wire logic modulus_ctrl,
    input wire logic [pvc_pkg::NUM_OSC-1:0] osc_enable,
    input wire logic [pvc_pkg::CAP_W-1:0] cap_code,
    // analog events
    output logic ref_pulse,
    output logic presc_pulse,
    output logic tune_above_target
);
    logic [7:0] ref_cnt;
    logic [3:0] pre_cnt;
    logic [1:0] osc_idx;
    // index of the one running oscillator
    always_comb begin
        osc_idx = 2'h0;
        for (int i = 0; i < NUM_OSC; i++) begin
            if (osc_enable[i]) begin
                osc_idx = i[1:0];
            end
        end
    end
    // comparator: above target while trial setting sits at or below the lock point
    assign tune_above_target = ({osc_idx, cap_code} <= tune_point);
    // reference edges and prescaler cycles, one vco cycle per clock
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ref_cnt <= 8'h00;
            pre_cnt <= 4'h0;
            ref_pulse <= 1'b0;
            presc_pulse <= 1'b0;
        end else begin
            ref_pulse <= (ref_cnt == 8'h00);
            ref_cnt <= (ref_cnt == 8'h00) ? ref_period - 8'h01 : ref_cnt - 8'h01;
            presc_pulse <= (pre_cnt == 4'h0);
            // reload with P or P+1 cycles as modulus control asks
            pre_cnt <= (pre_cnt == 4'h0) ?
                {1'b0, prescaler_ctrl, 2'h3} + {3'h0, modulus_ctrl} : pre_cnt - 4'h1;
        end
    end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pvc_pkg::*;
    logic sys_clk, rst, ref_pulse, presc_pulse, tune_above_target;
    logic fractional_mode, prescaler_select, calibration_trigger;
    logic oscillator_choice_mode, manual_tuning_select, output_enable_request;
    logic [INTEGER_DIVIDE_VALUE_W-1:0] integer_divide_value;
    logic [FRAC_W-1:0] fraction_divide_value;
    logic [REFERENCE_DIVIDER_W-1:0] reference_divider;
    logic [2:0] feedback_predivide_select, predivide_ctrl;
    logic [1:0] output_divide_select, calibration_accuracy, tune_voltage_target;
    logic [1:0] lo_divide_ctrl, cal_precision, tune_target_ctrl;
    logic [TSCL_W-1:0] calibration_tick_scale;
    logic [OSC_W-1:0] oscillator_choice;
    logic [CAP_W-1:0] capacitor_bank_code, cap_code;
    logic pfd_tick, fb_pulse, modulus_ctrl, prescaler_ctrl;
    logic cal_active, cal_done, cal_counter_overflow_flag, rf_lo_enable;
    logic [NUM_OSC-1:0] osc_enable;
    logic [RB_W-1:0] readback_word;
    logic [7:0] ref_period;
    logic [9:0] tune_point;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int d;
    logic [12:0] rdv [3] = '{13'h0001, 13'h0003, 13'h0000};
    int fb_n [5] = '{23, 23, 83, 80, 23};
    logic [24:0] fb_f [5] = '{25'h1000000, 25'h1000000, 25'h1000000, 25'h0, 25'h0800000};
    bit fb_m [5] = '{0, 1, 1, 0, 1};
    bit fb_p [5] = '{0, 0, 1, 1, 0};
    int fb_e [5] = '{184, 188, 668, 640, 186};

    pvc_top i_dut (
        .sys_clk, .rst, .ref_pulse, .presc_pulse, .tune_above_target, .fractional_mode,
        .integer_divide_value, .fraction_divide_value, .reference_divider,
        .feedback_predivide_select, .prescaler_select, .output_divide_select,
        .calibration_tick_scale, .calibration_trigger, .calibration_accuracy,
        .tune_voltage_target, .oscillator_choice_mode, .oscillator_choice,
        .capacitor_bank_code, .manual_tuning_select, .output_enable_request,
        .pfd_tick, .fb_pulse, .modulus_ctrl, .predivide_ctrl, .prescaler_ctrl,
        .lo_divide_ctrl, .osc_enable, .cap_code, .cal_precision, .tune_target_ctrl,
        .cal_active, .cal_done, .cal_counter_overflow_flag, .readback_word, .rf_lo_enable
    );
    pvc_analog_model i_model (
        .sys_clk, .rst, .ref_period, .tune_point, .prescaler_ctrl, .modulus_ctrl,
        .osc_enable, .cap_code, .ref_pulse, .presc_pulse, .tune_above_target
    );

    // free running clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // cycle count and hang guard
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            num_errors = num_errors + 1;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_in(input string nm, input int lo, input int hi, input int g);
        n_checks++;
        if (g < lo || g > hi) begin
            num_errors++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    // bounded wait for one pfd tick or feedback pulse
    task automatic wait_ev(input bit fb);
        int k;
        k = 0;
        do begin
            step(1);
            k++;
        end while (((fb ? fb_pulse : pfd_tick) !== 1'b1) && k < 5000);
        if (k >= 5000) chk("event wait", 1, 0);
    endtask
    task automatic gap(input bit fb, input int n, output int span);
        int t0;
        wait_ev(fb);
        t0 = cyc;
        repeat (n) wait_ev(fb);
        span = cyc - t0;
    endtask
    task automatic pulse_trig();
        calibration_trigger = 1'b1;
        step(1);
        calibration_trigger = 1'b0;
    endtask
    // one calibration, optionally restarted, then result checks
    task automatic run_cal(input int pre, input logic [1:0] eo, input logic [7:0] ec,
                           input int lo, input int hi);
        int k;
        k = 0;
        if (pre > 0) begin
            pulse_trig();
            step(pre);
        end
        pulse_trig();
        chk("cal_active", 1, cal_active);
        while (cal_active === 1'b1 && k < 2000) begin
            chk("one osc", 1, $countones(osc_enable));
            chk("rf_lo off", 0, rf_lo_enable);
            step(1);
            k++;
        end
        chk_in("cal cycles", lo, hi, k);
        chk("cal_done", 1, cal_done);
        chk("readback", {8'h00, eo, 1'b0, ec, 13'h0000}, readback_word);
        chk("osc_enable", 32'h1 << eo, osc_enable);
        chk("cap_code", ec, cap_code);
        chk("rf_lo on", 1, rf_lo_enable);
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        ref_period = 8'h02;
        tune_point = 10'h3A5;
        fractional_mode = 1'b0;
        integer_divide_value = 16'h0017;
        fraction_divide_value = 25'h1000000;
        reference_divider = 13'h0002;
        feedback_predivide_select = 3'h1;
        prescaler_select = 1'b0;
        output_divide_select = 2'h1;
        calibration_tick_scale = 8'h02;
        calibration_trigger = 1'b0;
        calibration_accuracy = 2'h2;
        tune_voltage_target = 2'h1;
        oscillator_choice_mode = 1'b0;
        oscillator_choice = 2'h0;
        capacitor_bank_code = 8'h11;
        manual_tuning_select = 1'b0;
        output_enable_request = 1'b1;
        step(6);
        chk("reset osc", 4'h1, osc_enable);
        chk("reset cap", 0, cap_code);
        chk("reset rf_lo", 0, rf_lo_enable);
        chk("reset readback", 0, readback_word);
        rst = 1'b0;
        step(2);
        chk("predivide", 3'h1, predivide_ctrl);
        chk("prescaler", 1'b0, prescaler_ctrl);
        chk("lo divide", 2'h1, lo_divide_ctrl);
        chk("precision", 2'h2, cal_precision);
        chk("target", 2'h1, tune_target_ctrl);
        for (int i = 0; i < 3; i++) begin
            reference_divider = rdv[i];
            step(20);
            gap(1'b0, 1, d);
            chk("pfd gap", 2 * ((rdv[i] == 0) ? 1 : rdv[i]), d);
        end
        reference_divider = 13'h0002;
        for (int i = 0; i < 5; i++) begin
            integer_divide_value = fb_n[i][15:0];
            fraction_divide_value = fb_f[i];
            fractional_mode = fb_m[i];
            prescaler_select = fb_p[i];
            repeat (3) wait_ev(1'b1);
            gap(1'b1, 8, d);
            chk("fb span", fb_e[i], d);
        end
        run_cal(0, 2'h3, 8'hA5, 19 * 8, 23 * 8);
        tune_point = 10'h000;
        step(30);
        chk("held osc", 4'h8, osc_enable);
        chk("held cap", 8'hA5, cap_code);
        tune_point = 10'h13C;
        oscillator_choice_mode = 1'b1;
        oscillator_choice = 2'h1;
        calibration_tick_scale = 8'h03;
        run_cal(40, 2'h1, 8'h3C, 15 * 12, 17 * 12);
        manual_tuning_select = 1'b1;
        oscillator_choice = 2'h2;
        capacitor_bank_code = 8'h5A;
        step(3);
        chk("manual osc", 4'h4, osc_enable);
        chk("manual cap", 8'h5A, cap_code);
        pulse_trig();
        step(2);
        chk("manual no cal", 0, cal_active);
        chk("manual readback", {8'h00, 2'h1, 1'b0, 8'h3C, 13'h0000}, readback_word);
        manual_tuning_select = 1'b0;
        // feedback far too fast for a slow tick
        integer_divide_value = 16'h0004;
        fractional_mode = 1'b0;
        reference_divider = 13'h0064;
        calibration_tick_scale = 8'h19;
        oscillator_choice_mode = 1'b0;
        tune_point = 10'h3A5;
        step(2);
        pulse_trig();
        step(15000);
        chk("overflow", 1, cal_counter_overflow_flag);
        chk("ovf rf_lo", 0, rf_lo_enable);
        integer_divide_value = 16'h0017;
        reference_divider = 13'h0002;
        calibration_tick_scale = 8'h02;
        step(20);
        run_cal(0, 2'h3, 8'hA5, 19 * 8, 23 * 8);
        chk("ovf cleared", 0, cal_counter_overflow_flag);
        close_out();
    end
endmodule
`default_nettype wire
